//--- one_shot_pulse_counter_tb.sv
`timescale 1ns/1ps
module one_shot_pulse_counter_tb;
  import osp_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, xrun = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, c1, c2;
  logic        hreadyout_o, hresp_o, pulse_out_o, irq_o, gate, xclk, trig;
  int          n_errors = 0, checks_done = 0, d, w;
  int          dv[5] = '{8, 4, 2, 1, 1};

  always #50 clk_i = ~clk_i;

  osp_top osp_top_i (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .gate_off_input_i(gate), .external_clock_input_i(xclk), .trigger_input_i(trig),
    .pulse_out_o(pulse_out_o), .irq_o(irq_o));
  osp_src_model osp_src_model_i (.clk_i(clk_i), .xclk_run_i(xrun), .gate_o(gate),
    .xclk_o(xclk), .trig_o(trig));

  // ==========================================================
  // reporting
  task automatic stop_test();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rng(input string n, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  // ==========================================================
  // AHB-Lite single word transfers
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("hready wait", 1, 0);
      stop_test();
    end
  endtask

  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] r);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr_en;
    hsize_i  <= 3'h2;
    wt();
    htrans_i <= 2'h0;
    hsel_i   <= 1'b0;
    hwdata_i <= dat;
    wt();
    r = hrdata_o;
    chk("hresp", 0, hresp_o);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic [31:0] r;
    bus(1'b1, a, dat, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    rd(a, r);
    chk($sformatf("read %h", a), e, r);
  endtask

  // ==========================================================
  // one-shot helpers; active level low so the pulse shows at the pin
  task automatic meas(output int dl, output int wd);
    dl = 0;
    wd = 0;
    while (pulse_out_o !== 1'b0 && dl < 3000) begin
      @(posedge clk_i);
      #1;
      dl++;
    end
    while (pulse_out_o === 1'b0 && wd < 3000) begin
      @(posedge clk_i);
      #1;
      wd++;
    end
    if (dl >= 3000 || wd >= 3000) begin
      chk("shot finished", 1, 0);
      stop_test();
    end
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    int          n;
    n = 0;
    do begin
      rd(OSP_OFF_STAT, s);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      chk("idle wait", 1, 0);
      stop_test();
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("pulse idle", 1, pulse_out_o);
    chk("irq idle", 0, irq_o);
    rdc(OSP_OFF_CTRL, 32'h0);
    rdc(OSP_OFF_CONSTB, 32'h0);
    rdc(OSP_OFF_BIE, 32'h0);
    rdc(8'hF0, 32'h0);
    wr(OSP_OFF_CTRL, 32'hFFFF_8C07);
    rdc(OSP_OFF_CTRL, 32'h0000_8C07);
    wr(OSP_OFF_CONSTB, 32'h0000_0004);
    rdc(OSP_OFF_CONSTB, 32'h0000_0004);
    wr(OSP_OFF_BIE, 32'h1);
    wr(OSP_OFF_CONSTA, 32'h3);
    // software trigger, 10 MHz count clock
    wr(OSP_OFF_TRIG, 32'h1);
    meas(d, w);
    rng("delay", 4, 5, d);
    rng("width", 5, 5, w);
    chk("irq set", 1, irq_o);
    wr(OSP_OFF_PEND, 32'h1);
    chk("irq cleared", 0, irq_o);
    wr(OSP_OFF_TRIG, 32'h1);
    meas(d, w);
    wr(OSP_OFF_CTRL, 32'h0C07);
    chk("irq off by enable", 0, irq_o);
    wr(OSP_OFF_BIE, 32'h0);
    wr(OSP_OFF_CTRL, 32'h8C07);
    wr(OSP_OFF_TRIG, 32'h1);
    meas(d, w);
    chk("irq board gated", 0, irq_o);
    // active high: the pin stays at its idle high level through the pulse
    wr(OSP_OFF_CTRL, 32'h0C0F);
    wr(OSP_OFF_TRIG, 32'h1);
    repeat (4) @(posedge clk_i);
    #1;
    chk("active high out", 1, pulse_out_o);
    rdc(OSP_OFF_STAT, 32'h0000_0007);
    wait_idle();
    wr(OSP_OFF_CONSTA, 32'h14);
    // every internal count rate
    for (int k = 0; k < 5; k++) begin
      wr(OSP_OFF_CTRL, {16'h0, 3'h0, 3'(k), 10'h007});
      wr(OSP_OFF_TRIG, 32'h1);
      meas(d, w);
      rng("width by source", 3 * dv[k] + 2, 4 * dv[k] + 1, w);
    end
    // external clock, ticks every 4 clk
    xrun <= 1'b1;
    wr(OSP_OFF_CTRL, 32'h1447);
    wr(OSP_OFF_TRIG, 32'h1);
    meas(d, w);
    rng("width ext clock", 14, 17, w);
    wr(OSP_OFF_CTRL, 32'h1407);
    wr(OSP_OFF_TRIG, 32'h1);
    repeat (120) @(posedge clk_i);
    rdc(OSP_OFF_STAT, 32'h5);
    wr(OSP_OFF_CTRL, 32'h0);
    rdc(OSP_OFF_STAT, 32'h4);
    xrun <= 1'b0;
    // external trigger, both polarities, then debounce
    wr(OSP_OFF_CTRL, 32'h0E07);
    osp_src_model_i.fire(1'b1, 3);
    meas(d, w);
    rng("width trig high", 5, 5, w);
    osp_src_model_i.set_pins(1'b0, 1'b1);
    wr(OSP_OFF_CTRL, 32'h0D07);
    osp_src_model_i.fire(1'b0, 3);
    meas(d, w);
    rng("width trig low", 5, 5, w);
    osp_src_model_i.set_pins(1'b0, 1'b0);
    wr(OSP_OFF_CTRL, 32'h2E07);
    repeat (40) @(posedge clk_i);
    osp_src_model_i.fire(1'b1, 20);
    repeat (60) @(posedge clk_i);
    rdc(OSP_OFF_STAT, 32'h4);
    osp_src_model_i.fire(1'b1, 40);
    meas(d, w);
    rng("width debounced", 5, 5, w);
    // each gate code; the pin at the stopping level for codes 01 and 10, high for the free-running codes 00 and 11
    for (int g = 0; g < 4; g++) begin
      osp_src_model_i.set_pins(g != 2, 1'b0);
      wr(OSP_OFF_CTRL, {16'h0, 6'h03, 4'h0, g[1:0], 4'h7});
      wr(OSP_OFF_TRIG, 32'h1);
      repeat (40) @(posedge clk_i);
      rd(OSP_OFF_COUNT, c1);
      rd(OSP_OFF_COUNT, c2);
      rdc(OSP_OFF_STAT, {29'h0, 1'b1, 1'b0, g == 1 || g == 2});
      if (g == 1 || g == 2) begin
        chk("gated count", 32'h0000_0014, c1);
        chk("gated count", c1, c2);
        chk("gated out", 1, pulse_out_o);
      end
      osp_src_model_i.set_pins(g == 2, 1'b0);
      wait_idle();
    end
    // quadrature: two A edges count up twice; index with A and B high reloads constant B
    wr(OSP_OFF_CTRL, 32'h0000_09A1);
    osp_src_model_i.set_pins(1'b1, 1'b0);
    osp_src_model_i.set_pins(1'b0, 1'b0);
    repeat (6) @(posedge clk_i);
    rdc(OSP_OFF_COUNT, 32'h0000_0002);
    osp_src_model_i.set_pins(1'b1, 1'b0);
    xrun <= 1'b1;
    repeat (16) @(posedge clk_i);
    xrun <= 1'b0;
    repeat (6) @(posedge clk_i);
    rdc(OSP_OFF_COUNT, 32'h0000_0004);
    osp_src_model_i.set_pins(1'b0, 1'b0);
    // 16-bit size drops the upper half of the constant; 32-bit keeps it
    wr(OSP_OFF_CONSTA, 32'h0001_0003);
    wr(OSP_OFF_CTRL, 32'h0C07);
    wr(OSP_OFF_TRIG, 32'h1);
    meas(d, w);
    rng("delay 16 bit", 4, 5, d);
    wr(OSP_OFF_CTRL, 32'h4C07);
    wr(OSP_OFF_TRIG, 32'h1);
    repeat (40) @(posedge clk_i);
    rdc(OSP_OFF_STAT, 32'h5);
    stop_test();
  end
endmodule

//--- osp_cond.sv
`timescale 1ns/1ps
module osp_cond (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic gate_pin_i,
  input  wire logic xclk_pin_i,
  input  wire logic trig_pin_i,
  osp_pin_if.cond   pins
);
  import osp_pkg::*;

  // ==========================================================
  // synchronisers: first stage feeds only the second
  logic [2:0]            s1_q;
  logic [2:0]            s2_q;
  logic                  x3_q;
  logic [1:0]            filt_q;
  logic [OSP_DBNC_W-1:0] dcnt_q [2];
  wire  [1:0]            raw = {s2_q[2], s2_q[0]};

  localparam logic [OSP_DBNC_W-1:0] DLAST = OSP_DBNC_W'(OSP_DBNC_CYC);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      x3_q <= 1'b0;
    end else begin
      s1_q <= {trig_pin_i, xclk_pin_i, gate_pin_i};
      s2_q <= s1_q;
      x3_q <= s2_q[1];
    end
  end

  // ==========================================================
  // glitch filter: a new level is taken only after it has held longer than the reject width
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_q    <= 2'h0;
      dcnt_q[0] <= '0;
      dcnt_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!pins.dbnc_en || raw[i] == filt_q[i] || dcnt_q[i] == DLAST) begin // R18
          filt_q[i] <= raw[i];
          dcnt_q[i] <= '0;
        end else begin
          dcnt_q[i] <= dcnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign pins.gate_lvl  = filt_q[0];
  assign pins.trig_lvl  = filt_q[1];
  assign pins.xclk_lvl  = s2_q[1];
  // sampled at the system clock: external clocks well below half its rate are counted edge for edge
  assign pins.xclk_rise = s2_q[1] & ~x3_q; // R09
endmodule

//--- osp_pin_if.sv
`timescale 1ns/1ps
interface osp_pin_if;
  logic dbnc_en;
  logic gate_lvl;
  logic trig_lvl;
  logic xclk_lvl;
  logic xclk_rise;
  modport cond (input dbnc_en, output gate_lvl, output trig_lvl, output xclk_lvl, output xclk_rise);
  modport core (output dbnc_en, input gate_lvl, input trig_lvl, input xclk_lvl, input xclk_rise);
endinterface

//--- osp_pkg.sv
package osp_pkg;

  // ==========================================================
  // clock and bus
  localparam int OSP_CLK_HZ = 10_000_000;
  localparam int OSP_CLK_NS = 100;
  localparam int OSP_AW     = 32;
  localparam int OSP_DW     = 32;
  localparam int OSP_DEC_W  = 8;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OSP_OFF_BIE    = 8'h00;
  localparam logic [7:0] OSP_OFF_PEND   = 8'h04;
  localparam logic [7:0] OSP_OFF_TRIG   = 8'h1C;
  localparam logic [7:0] OSP_OFF_CTRL   = 8'h20;
  localparam logic [7:0] OSP_OFF_STAT   = 8'h40;
  localparam logic [7:0] OSP_OFF_COUNT  = 8'h44;
  localparam logic [7:0] OSP_OFF_CONSTA = 8'h60;
  localparam logic [7:0] OSP_OFF_CONSTB = 8'h80;

  // ==========================================================
  // control word fields and codes
  localparam int OSP_F_MODE = 0;
  localparam int OSP_F_OPOL = 3;
  localparam int OSP_F_GATE = 4;
  localparam int OSP_F_XCLK = 6;
  localparam int OSP_F_TRIG = 8;
  localparam int OSP_F_CSRC = 10;
  localparam int OSP_F_DBNC = 13;
  localparam int OSP_F_SIZE = 14;
  localparam int OSP_F_IE   = 15;
  localparam int OSP_F_QENC = 4;
  localparam int OSP_F_QBEN = 6;
  localparam int OSP_F_QIDX = 7;
  localparam int OSP_F_QRLD = 10;

  localparam logic [2:0] OSP_MODE_OS    = 3'h7;
  localparam logic [2:0] OSP_MODE_QD    = 3'h1;
  localparam logic [1:0] OSP_POL_LOW    = 2'h1;
  localparam logic [1:0] OSP_POL_HIGH   = 2'h2;
  localparam logic [2:0] OSP_CSRC_1M25  = 3'h0;
  localparam logic [2:0] OSP_CSRC_2M5   = 3'h1;
  localparam logic [2:0] OSP_CSRC_5M    = 3'h2;
  localparam logic [2:0] OSP_CSRC_10M   = 3'h3;
  localparam logic [2:0] OSP_CSRC_20M   = 3'h4;
  localparam logic [2:0] OSP_CSRC_EXT   = 3'h5;
  localparam logic [1:0] OSP_QENC_X2    = 2'h2;
  localparam logic [2:0] OSP_QIDX_AB    = 3'h3;
  localparam logic [1:0] OSP_QRLD_IRQ   = 2'h2;

  // ==========================================================
  // reset values
  localparam logic [15:0] OSP_CTRL_RST  = 16'h0000;
  localparam logic [31:0] OSP_CONST_RST = 32'h0000_0000;
  localparam logic        OSP_BIE_RST   = 1'b0;

  // ==========================================================
  // timing
  function automatic int osp_cyc_ceil(input int ns);
    osp_cyc_ceil = (ns + OSP_CLK_NS - 1) / OSP_CLK_NS;
    if (osp_cyc_ceil < 1) osp_cyc_ceil = 1;
  endfunction

  function automatic int osp_div(input int hz);
    osp_div = OSP_CLK_HZ / hz;
    if (osp_div < 1) osp_div = 1;
  endfunction

  localparam int OSP_ZDET_NS  = 50;
  localparam int OSP_ZDET_CYC = osp_cyc_ceil(OSP_ZDET_NS);
  localparam int OSP_DBNC_NS  = 2400;
  localparam int OSP_DBNC_CYC = osp_cyc_ceil(OSP_DBNC_NS);
  localparam int OSP_DBNC_W   = 5;
  localparam int OSP_DIV_1M25 = osp_div(1_250_000);
  localparam int OSP_DIV_2M5  = osp_div(2_500_000);
  localparam int OSP_DIV_5M   = osp_div(5_000_000);
  localparam int OSP_DIV_10M  = osp_div(10_000_000);
  localparam int OSP_DIV_20M  = osp_div(20_000_000);

  typedef enum logic [1:0] {OSP_IDLE, OSP_DELAY, OSP_PULSE} osp_state_t;

endpackage

//--- osp_src_model.sv
`timescale 1ns/1ps
module osp_src_model (
  input  wire logic clk_i,
  input  wire logic xclk_run_i,
  output logic      gate_o,
  output logic      xclk_o,
  output logic      trig_o
);
  logic [1:0] ph_q;

  initial begin
    gate_o = 1'b0;
    trig_o = 1'b0;
    xclk_o = 1'b0;
    ph_q   = 2'h0;
  end

  // ==========================================================
  // external clock at 2.5 MHz, inside the accepted rate; parked low when stopped
  always @(posedge clk_i) begin
    ph_q   <= xclk_run_i ? ph_q + 2'h1 : 2'h0;
    xclk_o <= xclk_run_i & ph_q[1];
  end

  // ==========================================================
  // pin levels change just after an edge
  task automatic set_pins(input logic g, input logic t);
    @(posedge clk_i);
    gate_o <= g;
    trig_o <= t;
  endtask

  // one trigger per call; the bench waits for idle before the next one
  task automatic fire(input logic act, input int w);
    @(posedge clk_i);
    trig_o <= act;
    repeat (w) @(posedge clk_i);
    trig_o <= ~act;
  endtask
endmodule

//--- osp_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: mode code 111 selects one-shot
// R02: trigger starts countdown of constant A
// R03: constant B sets active pulse length
// R04: at zero toggle output, load B
// R05: N counts plus zero-detect delay
// R06: gate-off polarity codes 01, 10 gate
// R07: external clock needs enable and source 101
// R08: clock source selects internal divided rates
// R09: external clock accepted up to maximum rate
// R10: trigger polarity codes 01 low, 10 high
// R11: trigger register write starts one-shot
// R12: one trigger yields the complete pulse
// R13: no retrigger before pulse finishes
// R14: interrupt on each output transition
// R15: pending until write one clears
// R16: clearing enable bit clears pending
// R17: output idles high, bit 3 active level
// R18: debounce rejects short gate, trigger pulses
// R19: bit 14 selects 16 or 32 bits
// R20: 32-bit use consumes the partner counter (only one channel is modelled here; its own counter is 32 bits wide)
// R21: quadrature two-times encoding, channel B enable
// R22: quadrature index reload and interrupt
// R23: gated counter holds count and output
module osp_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       hsel_i,
  input  wire logic [osp_pkg::OSP_AW-1:0] haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [osp_pkg::OSP_DW-1:0] hwdata_i,
  input  wire logic                       hready_i,
  output logic      [osp_pkg::OSP_DW-1:0] hrdata_o,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  input  wire logic                       gate_off_input_i,
  input  wire logic                       external_clock_input_i,
  input  wire logic                       trigger_input_i,
  output logic                            pulse_out_o,
  output logic                            irq_o
);
  import osp_pkg::*;

  // ==========================================================
  // pin conditioning
  osp_pin_if pins ();

  osp_cond u_cond (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .gate_pin_i (gate_off_input_i),
    .xclk_pin_i (external_clock_input_i),
    .trig_pin_i (trigger_input_i),
    .pins       (pins.cond)
  );

  // ==========================================================
  // state
  logic             dp_wr_q;
  logic [7:0]       dp_addr_q;
  logic [31:0]      hrdata_q;
  logic             bie_q;
  logic [15:0]      ctrl_q;
  logic [31:0]      consta_q;
  logic [31:0]      constb_q;
  logic             pend_q;
  logic [2:0]       pre_q;
  logic             trig_act_q;
  logic             a_q;
  logic             idx_q;
  logic             out_q;
  osp_state_t       state_q;
  osp_state_t       state_d;
  logic [31:0]      cnt_q;
  logic [31:0]      cnt_d;
  logic [3:0]       zdet_q;
  logic [3:0]       zdet_d;

  localparam logic [3:0] ZLAST = 4'(OSP_ZDET_CYC - 1);

  function automatic logic hit(input logic [2:0] pre, input int div);
    hit = (pre & 3'(div - 1)) == 3'(div - 1);
  endfunction

  // a 16-bit channel never carries bits above 15
  function automatic logic [31:0] ld(input logic [31:0] v, input logic wide);
    ld = wide ? v : {16'h0000, v[15:0]};
  endfunction

  // ==========================================================
  // bus slave: zero wait states, read data latched in the address phase
  wire       ap_take = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] ap_addr = haddr_i[7:0];

  wire wr_bie    = dp_wr_q && dp_addr_q == OSP_OFF_BIE;
  wire wr_pend   = dp_wr_q && dp_addr_q == OSP_OFF_PEND;
  wire wr_trig   = dp_wr_q && dp_addr_q == OSP_OFF_TRIG;
  wire wr_ctrl   = dp_wr_q && dp_addr_q == OSP_OFF_CTRL;
  wire wr_consta = dp_wr_q && dp_addr_q == OSP_OFF_CONSTA;
  wire wr_constb = dp_wr_q && dp_addr_q == OSP_OFF_CONSTB;

  wire [31:0] rd_mux =
    (ap_addr == OSP_OFF_BIE)    ? {31'h0, bie_q} :
    (ap_addr == OSP_OFF_PEND)   ? {31'h0, pend_q} :
    (ap_addr == OSP_OFF_CTRL)   ? {16'h0000, ctrl_q} :
    (ap_addr == OSP_OFF_STAT)   ? {29'h0, out_q, state_q == OSP_PULSE, state_q != OSP_IDLE} :
    (ap_addr == OSP_OFF_COUNT)  ? cnt_q :
    (ap_addr == OSP_OFF_CONSTA) ? consta_q :
    (ap_addr == OSP_OFF_CONSTB) ? constb_q :
    32'h0000_0000;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dp_wr_q     <= 1'b0;
      dp_addr_q   <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      dp_wr_q     <= ap_take & hwrite_i;
      dp_addr_q   <= ap_addr;
      hrdata_q    <= (ap_take & ~hwrite_i) ? rd_mux : hrdata_q;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  assign hrdata_o = hrdata_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bie_q    <= OSP_BIE_RST;
      ctrl_q   <= OSP_CTRL_RST;
      consta_q <= OSP_CONST_RST;
      constb_q <= OSP_CONST_RST;
    end else begin
      if (wr_bie) bie_q <= hwdata_i[0];
      if (wr_ctrl) ctrl_q <= hwdata_i[15:0];
      if (wr_consta) consta_q <= hwdata_i;
      if (wr_constb) constb_q <= hwdata_i;
    end
  end

  // ==========================================================
  // control decode
  wire [2:0] mode      = ctrl_q[OSP_F_MODE +: 3];
  wire       mode_os   = mode == OSP_MODE_OS; // R01
  wire       mode_qd   = mode == OSP_MODE_QD;
  wire       wide      = ctrl_q[OSP_F_SIZE]; // R19
  wire [1:0] gate_code = ctrl_q[OSP_F_GATE +: 2];
  wire [1:0] xclk_code = ctrl_q[OSP_F_XCLK +: 2];
  wire [1:0] trig_code = ctrl_q[OSP_F_TRIG +: 2];
  wire [2:0] csrc      = ctrl_q[OSP_F_CSRC +: 3];
  wire       opol      = ctrl_q[OSP_F_OPOL];

  assign pins.dbnc_en = ctrl_q[OSP_F_DBNC]; // R18

  // codes 00 and 11 leave the counter free running
  wire run = (gate_code == OSP_POL_LOW)  ? ~pins.gate_lvl :
             (gate_code == OSP_POL_HIGH) ? pins.gate_lvl : 1'b1; // R06

  // ==========================================================
  // count clock: 20 MHz cannot exceed the system rate, so it ticks every cycle like 10 MHz
  wire xclk_en = (xclk_code == OSP_POL_LOW || xclk_code == OSP_POL_HIGH) && csrc == OSP_CSRC_EXT; // R07
  wire tick =
    (csrc == OSP_CSRC_1M25) ? hit(pre_q, OSP_DIV_1M25) :
    (csrc == OSP_CSRC_2M5)  ? hit(pre_q, OSP_DIV_2M5) :
    (csrc == OSP_CSRC_5M)   ? hit(pre_q, OSP_DIV_5M) :
    (csrc == OSP_CSRC_10M)  ? hit(pre_q, OSP_DIV_10M) :
    (csrc == OSP_CSRC_20M)  ? hit(pre_q, OSP_DIV_20M) :
    xclk_en & pins.xclk_rise; // R08 R09

  // ==========================================================
  // triggers: edge into the active level so a held level does not retrigger
  wire trig_act = (trig_code == OSP_POL_LOW)  ? ~pins.trig_lvl :
                  (trig_code == OSP_POL_HIGH) ? pins.trig_lvl : 1'b0; // R10
  wire trig_ext = trig_act & ~trig_act_q;
  wire trig_any = mode_os && (wr_trig || trig_ext); // R11

  // ==========================================================
  // quadrature: gate pin is channel A, external clock pin is channel B
  wire a_edge   = pins.gate_lvl ^ a_q;
  wire q_x2     = ctrl_q[OSP_F_QENC +: 2] == OSP_QENC_X2;
  wire q_up     = ~ctrl_q[OSP_F_QBEN] | (pins.gate_lvl ^ pins.xclk_lvl); // R21
  wire idx      = ctrl_q[OSP_F_QIDX +: 3] == OSP_QIDX_AB && pins.gate_lvl && pins.xclk_lvl; // R22
  wire idx_rise = idx & ~idx_q;
  wire q_rld    = ctrl_q[OSP_F_QRLD +: 2] == OSP_QRLD_IRQ;
  wire [31:0] quad_cnt =
    (idx_rise && q_rld) ? ld(constb_q, wide) :
    (a_edge && q_x2)    ? ld(q_up ? cnt_q + 32'h1 : cnt_q - 32'h1, wide) :
    cnt_q; // R21 R22

  // ==========================================================
  // one-shot sequencer; retriggers while busy are ignored
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    zdet_d  = zdet_q;
    case (state_q)
      OSP_IDLE: begin
        if (mode_qd) begin
          cnt_d = quad_cnt;
        end else if (trig_any) begin
          state_d = OSP_DELAY;
          cnt_d   = ld(consta_q, wide); // R02 R12
          zdet_d  = 4'h0;
        end
      end
      OSP_DELAY, OSP_PULSE: begin
        if (!mode_os) begin
          state_d = OSP_IDLE;
        end else if (!run) begin
          state_d = state_q; // R23
        end else if (cnt_q == 32'h0 && zdet_q == ZLAST) begin
          zdet_d = 4'h0;
          if (state_q == OSP_DELAY) begin
            state_d = OSP_PULSE; // R04
            cnt_d   = ld(constb_q, wide); // R03
          end else begin
            state_d = OSP_IDLE;
          end
        end else if (cnt_q == 32'h0) begin
          zdet_d = zdet_q + 4'h1; // R05
        end else if (tick) begin
          cnt_d = cnt_q - 32'h1; // R04
        end
      end
      default: begin
        state_d = OSP_IDLE;
      end
    endcase
  end

  // ==========================================================
  // output and interrupt
  wire act_d   = (mode_os && state_d == OSP_PULSE) || (mode_qd && idx);
  wire out_d   = act_d ? opol : 1'b1; // R17 R03
  wire os_evt  = mode_os && ((state_d == OSP_PULSE) != (state_q == OSP_PULSE));
  wire ie_ok   = ctrl_q[OSP_F_IE] & bie_q;
  wire pend_set = ie_ok & (os_evt | (mode_qd & idx_rise & q_rld)); // R14 R22
  wire pend_clr = (wr_pend & hwdata_i[0]) | (wr_ctrl & ~hwdata_i[OSP_F_IE]); // R15 R16
  wire pend_d   = pend_set | (pend_q & ~pend_clr);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= OSP_IDLE;
      cnt_q      <= 32'h0000_0000;
      zdet_q     <= 4'h0;
      pre_q      <= 3'h0;
      trig_act_q <= 1'b0;
      a_q        <= 1'b0;
      idx_q      <= 1'b0;
      out_q      <= 1'b1;
      pend_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      zdet_q     <= zdet_d;
      pre_q      <= pre_q + 3'h1;
      trig_act_q <= trig_act;
      a_q        <= pins.gate_lvl;
      idx_q      <= idx;
      out_q      <= out_d;
      pend_q     <= pend_d;
    end
  end

  assign pulse_out_o = out_q;
  assign irq_o       = pend_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sw_trig_idle;
    wr_trig && state_q == OSP_IDLE && mode_os;
  endsequence

  sequence s_zero_reached;
    state_q != OSP_IDLE && mode_os && run && cnt_q == 32'h0 && $past(cnt_q) == 32'h1;
  endsequence

  property p_mode_gate;
    state_q == OSP_IDLE && !mode_os && wr_trig |=> state_q == OSP_IDLE;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("trigger started outside one-shot mode"); // R01

  property p_trig_load;
    s_sw_trig_idle |=> state_q == OSP_DELAY && cnt_q == ld($past(consta_q), $past(wide));
  endproperty
  a_trig_load: assert property (p_trig_load) else $error("software trigger did not load constant A"); // R11

  property p_delay_to_pulse;
    state_q == OSP_DELAY && mode_os && run && cnt_q == 32'h0 && zdet_q == ZLAST
      |=> state_q == OSP_PULSE && cnt_q == ld($past(constb_q), $past(wide)) ##1 state_q != OSP_IDLE;
  endproperty
  a_delay_to_pulse: assert property (p_delay_to_pulse) else $error("zero count did not load constant B"); // R04

  property p_zero_extra;
    s_zero_reached ##0 ($stable(ctrl_q) && run) |=> $changed(state_q);
  endproperty
  a_zero_extra: assert property (p_zero_extra) else $error("zero detect not one cycle later"); // R05

  property p_out_level;
    mode_os && $stable(ctrl_q) |-> pulse_out_o == ((state_q == OSP_PULSE) ? opol : 1'b1);
  endproperty
  a_out_level: assert property (p_out_level) else $error("output level wrong for state"); // R17

  property p_gate_hold;
    mode_os && !run && state_q != OSP_IDLE && $stable(ctrl_q) |=> $stable(cnt_q) && $stable(state_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated counter moved"); // R23

  property p_irq_set;
    mode_os && $changed(pulse_out_o) && $past(ie_ok) && $past(mode_os) && $stable(ctrl_q) |-> pend_q;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("output edge raised no interrupt"); // R14

  property p_irq_hold;
    pend_q && !wr_pend && !wr_ctrl |=> pend_q;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("pending interrupt dropped"); // R15

  property p_ie_clear;
    wr_ctrl && !hwdata_i[OSP_F_IE] && !pend_set |=> !pend_q;
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("enable clear left interrupt pending"); // R16

  property p_size16;
    (s_sw_trig_idle and !wide) |=> cnt_q[31:16] == 16'h0000;
  endproperty
  a_size16: assert property (p_size16) else $error("16-bit channel loaded upper bits"); // R19

  // a 32-bit channel takes the partner's counter; this block models only the first channel
  property p_busy_ignore;
    state_q == OSP_DELAY && trig_any && !run && mode_os && $stable(ctrl_q) |=> state_q == OSP_DELAY;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("retrigger restarted a running pulse"); // R12 R20

endmodule
